/* src_sysref_capture.sv */
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ns
// How it works
// - While the flag reset bit is one, all status flags and counters are held cleared.
// - Transition select picks rising (0) or falling (1) changes of sampled SYSREF as events.
// - Edge select picks the rising (0) or falling (1) sample clock edge for sampling SYSREF.
// - Mode field selects disabled, continuous, or N-shot where zero skip acts on the next event.
// - N-shot discards the first N events, N from 0 to 15, and acts on the next one.
// - The negative window gives 0 to 3 clocks of tolerance for early events.
// - The positive window gives 0 to 3 clocks of tolerance for late events.
// - A zero window demands capture exactly on the expected clock.
// - The timestamp pulse is delayed by 0 to 127 sample clock cycles.
// - An eight-bit wrapping count of captured events is cleared by flag reset.
module src_sysref_capture
  import src_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sysref_in,
  input wire logic expected_tick,
  output logic sysref_event,
  output logic sysref_timestamp,
  output logic irq
);
  logic [7:0] capture_control;
  logic [7:0] skip_count;
  logic [7:0] skew_window;
  logic [7:0] timestamp_delay;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_enable;
  logic [7:0] event_count;
  logic [3:0] setup_status;
  logic [3:0] hold_status;
  logic sample_rise;
  logic sample_fall;
  logic sample_prev;
  logic [3:0] skip_left;
  logic [2:0] since_tick;
  logic [2:0] early_wait;
  logic early_pending;
  logic bus_done;
  src_state_t state;

  // Single wait cycle: the access completes on the second edge of the request.
  assign avs_waitrequest = (avs_read | avs_write) & ~bus_done;
  // A write with byte lane 0 off is dropped, since every register lives in that lane.
  wire wr_take = avs_write & bus_done & avs_byteenable[0];
  wire [9:0] reg_idx = avs_address[ADDR_W-1:2];
  wire [7:0] wbyte = avs_writedata[7:0];
  wire flag_reset = capture_control[FLAG_RESET_BIT];
  wire trans_sel = capture_control[TRANS_SEL_BIT];
  wire edge_sel = capture_control[EDGE_SEL_BIT];
  wire [1:0] mode = capture_control[MODE_LSB+:2];
  wire [1:0] neg_win = skew_window[NEG_LSB+:2];
  wire [1:0] pos_win = skew_window[POS_LSB+:2];

  // The falling-edge sample is retimed to clk so all later logic stays single edge.
  always_ff @(posedge clk) begin
    if (rst) begin
      sample_rise <= 1'b0;
    end else begin
      sample_rise <= sysref_in;
    end
  end
  // The falling-edge flop gives the posedge logic only half a period of settling time,
  // which is the price of offering both sampling edges without a faster clock.
  always_ff @(negedge clk) begin
    if (rst) begin
      sample_fall <= 1'b0;
    end else begin
      sample_fall <= sysref_in;
    end
  end
  wire sample_sel = edge_sel ? sample_fall : sample_rise;
  always_ff @(posedge clk) begin
    if (rst) begin
      sample_prev <= 1'b0;
    end else begin
      sample_prev <= sample_sel;
    end
  end
  // Changing trans_sel while enabled can fake one event; software keeps mode disabled.
  wire raw_event = trans_sel ? (sample_prev & ~sample_sel) : (~sample_prev & sample_sel);

  // Window check against the expected clock tick.
  // Late events are measured from the last tick; early ones wait up to neg_win clocks for it.
  always_ff @(posedge clk) begin
    if (rst) begin
      since_tick <= 3'h7;
    end else if (expected_tick) begin
      since_tick <= 3'h0;
    end else if (since_tick != 3'h7) begin
      since_tick <= since_tick + 3'h1;
    end
  end
  wire on_time = raw_event & expected_tick;
  wire late_ok = raw_event & ~expected_tick & (since_tick != 3'h7)
                 & ((since_tick + 3'h1) <= {1'b0, pos_win});
  wire early_hit = early_pending & expected_tick;
  wire early_miss = early_pending & ~expected_tick & (early_wait == 3'h0);
  wire start_early = raw_event & ~on_time & ~late_ok & (neg_win != 2'h0);
  wire bad_event = (raw_event & ~on_time & ~late_ok & (neg_win == 2'h0)) | early_miss;
  always_ff @(posedge clk) begin
    if (rst) begin
      early_pending <= 1'b0;
      early_wait <= 3'h0;
    end else if (start_early) begin
      early_pending <= 1'b1;
      early_wait <= {1'b0, neg_win} - 3'h1;
    end else if (early_hit | early_miss) begin
      early_pending <= 1'b0;
    end else if (early_pending) begin
      early_wait <= early_wait - 3'h1;
    end
  end
  wire good_event = on_time | late_ok | early_hit;

  // Mode sequencing.
  // The reserved mode code 3 behaves as disabled, so a stray write cannot start capture.
  // A finished N-shot only rearms by passing through disabled or continuous.
  wire mode_off = (mode == SRC_MODE_OFF) | (mode == 2'h3);
  wire nshot = mode == SRC_MODE_NSHOT;
  logic act;
  src_state_t next_state;
  always_comb begin
    next_state = state;
    act = 1'b0;
    if (mode_off) begin
      next_state = SRC_ST_IDLE;
    end else begin
      unique case (state)
        SRC_ST_IDLE: begin
          if (!nshot) begin
            next_state = SRC_ST_ARMED;
            act = good_event;
          end else if (skip_count[3:0] == 4'h0) begin
            next_state = SRC_ST_ARMED;
            act = good_event;
            if (good_event) next_state = SRC_ST_DONE;
          end else begin
            next_state = SRC_ST_SKIP;
          end
        end
        SRC_ST_SKIP: begin
          if (good_event && skip_left == 4'h1) next_state = SRC_ST_ARMED;
        end
        SRC_ST_ARMED: begin
          act = good_event;
          if (good_event && nshot) next_state = SRC_ST_DONE;
        end
        SRC_ST_DONE: begin
          if (!nshot) next_state = SRC_ST_ARMED;
        end
        default: next_state = SRC_ST_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= SRC_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end
  // The skip budget is loaded while idle; a new count takes effect after the next pass through disabled.
  always_ff @(posedge clk) begin
    if (rst) begin
      skip_left <= 4'h0;
    end else if (state == SRC_ST_IDLE) begin
      skip_left <= skip_count[3:0];
    end else if (state == SRC_ST_SKIP && good_event) begin
      skip_left <= skip_left - 4'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      sysref_event <= 1'b0;
    end else begin
      sysref_event <= act;
    end
  end

  // The timestamp path taps the same act pulse as sysref_event, so a zero delay lines the two up.
  src_delay_line u_delay (
    .clk(clk),
    .rst(rst),
    .din(act),
    .tap(timestamp_delay[6:0]),
    .dout(sysref_timestamp)
  );

  // Margin status: setup counts early-window hits, hold counts late-window hits, saturating.
  always_ff @(posedge clk) begin
    if (rst || flag_reset) begin
      setup_status <= 4'h0;
      hold_status <= 4'h0;
      event_count <= 8'h00;
    end else begin
      if (early_hit && setup_status != 4'hF) setup_status <= setup_status + 4'h1;
      if (late_ok && hold_status != 4'hF) hold_status <= hold_status + 4'h1;
      if (act) event_count <= event_count + 8'h01;
    end
  end

  // Interrupts: set wins over clear.
  // A clear that meets a new event in the same cycle leaves the bit set, so no event is lost.
  wire [IRQ_W-1:0] irq_set = {nshot & act, bad_event, act};
  wire irq_clr_hit = wr_take & (reg_idx == IDX_IRQ_CLEAR);
  wire [IRQ_W-1:0] irq_clr = irq_clr_hit ? wbyte[IRQ_W-1:0] : '0;
  always_ff @(posedge clk) begin
    if (rst || flag_reset) begin
      irq_status <= IRQ_RESET;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
    end
  end
  assign irq = |(irq_status & irq_enable);

  // Register writes.
  // Reserved bits are masked on the way in, so they always read back as zero.
  always_ff @(posedge clk) begin
    if (rst) begin
      capture_control <= RESET_VALUE;
      skip_count <= RESET_VALUE;
      skew_window <= RESET_VALUE;
      timestamp_delay <= RESET_VALUE;
      irq_enable <= IRQ_RESET;
    end else if (wr_take) begin
      if (reg_idx == IDX_CAPTURE_CONTROL) capture_control <= wbyte & CONTROL_MASK;
      if (reg_idx == IDX_SKIP_COUNT) skip_count <= wbyte & SKIP_MASK;
      if (reg_idx == IDX_SKEW_WINDOW) skew_window <= wbyte & SKEW_MASK;
      if (reg_idx == IDX_TIMESTAMP_DELAY) timestamp_delay <= wbyte & DELAY_MASK;
      if (reg_idx == IDX_IRQ_ENABLE) irq_enable <= wbyte[IRQ_W-1:0];
    end
  end

  // Read mux; unmapped addresses read zero.
  // Read data is captured in the request's first cycle and stands until the next read.
  wire [7:0] rd_byte =
    (reg_idx == IDX_CAPTURE_CONTROL) ? capture_control :
    (reg_idx == IDX_SKIP_COUNT) ? skip_count :
    (reg_idx == IDX_SKEW_WINDOW) ? skew_window :
    (reg_idx == IDX_TIMESTAMP_DELAY) ? timestamp_delay :
    (reg_idx == IDX_SETUP_HOLD_STATUS) ? {hold_status, setup_status} :
    (reg_idx == IDX_EVENT_COUNT) ? event_count :
    (reg_idx == IDX_IRQ_STATUS) ? {5'h00, irq_status} :
    (reg_idx == IDX_IRQ_ENABLE) ? {5'h00, irq_enable} : 8'h00;
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_done <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      bus_done <= (avs_read | avs_write) & ~bus_done;
      if (avs_read & ~bus_done) avs_readdata <= {24'h00_0000, rd_byte};
    end
  end

  // Checks.
  flag_clear_a: assert property (@(posedge clk) disable iff (rst)
    $past(flag_reset) |-> (setup_status == 4'h0 && hold_status == 4'h0 && event_count == 8'h00))
    else $error("Status not cleared under flag reset.");
  rise_event_a: assert property (@(posedge clk) disable iff (rst)
    raw_event && !trans_sel |-> sample_sel && !sample_prev)
    else $error("Rising transition select saw a wrong change.");
  off_quiet_a: assert property (@(posedge clk) disable iff (rst)
    mode_off |=> !sysref_event)
    else $error("Event acted on while disabled.");
  nshot_once_a: assert property (@(posedge clk) disable iff (rst)
    (state == SRC_ST_DONE && nshot && $stable(mode)) |-> !act)
    else $error("N-shot acted after it was done.");
  exact_window_a: assert property (@(posedge clk) disable iff (rst)
    (skew_window[3:0] == 4'h0 && raw_event && !expected_tick) |-> !good_event)
    else $error("Zero window accepted an off-tick event.");
  late_bound_a: assert property (@(posedge clk) disable iff (rst)
    late_ok |-> since_tick < {1'b0, pos_win})
    else $error("Late event beyond positive window accepted.");
  stamp_zero_a: assert property (@(posedge clk) disable iff (rst)
    (timestamp_delay == 8'h00 && $stable(timestamp_delay)) |=> sysref_timestamp == $past(act))
    else $error("Zero delay timestamp misaligned.");
  count_step_a: assert property (@(posedge clk) disable iff (rst)
    (act && !flag_reset) |=> event_count == $past(event_count) + 8'h01)
    else $error("Event counter did not advance.");
  edge_pick_a: assert property (@(posedge clk) disable iff (rst)
    !edge_sel |-> sample_sel == sample_rise)
    else $error("Rising edge sample not selected.");

  // Flag reset and interrupt status.
  flag_irq_a: assert property (@(posedge clk) disable iff (rst)
    $past(flag_reset) |-> irq_status == IRQ_RESET)
    else $error("Interrupt status not cleared under flag reset.");
  bad_flag_a: assert property (@(posedge clk) disable iff (rst)
    (bad_event && !flag_reset) |=> irq_status[1])
    else $error("Rejected event did not set its status bit.");

  // Falling transitions and mode sequencing.
  // A skipped event must neither act nor disturb the budget it does not spend.
  fall_event_a: assert property (@(posedge clk) disable iff (rst)
    raw_event && trans_sel |-> !sample_sel && sample_prev)
    else $error("Falling transition select saw a wrong change.");
  event_follow_a: assert property (@(posedge clk) disable iff (rst)
    act |=> sysref_event)
    else $error("Acted event gave no event pulse.");
  cont_all_a: assert property (@(posedge clk) disable iff (rst)
    (mode == SRC_MODE_CONT && state == SRC_ST_ARMED && good_event) |-> act)
    else $error("Continuous mode dropped a good event.");
  skip_quiet_a: assert property (@(posedge clk) disable iff (rst)
    state == SRC_ST_SKIP |-> !act)
    else $error("N-shot acted while still skipping.");
  skip_hold_a: assert property (@(posedge clk) disable iff (rst)
    (state == SRC_ST_SKIP && !good_event) |=> skip_left == $past(skip_left))
    else $error("Skip budget moved without an event.");

  // Skew windows; a window change while an early event waits is outside these checks.
  late_window_a: assert property (@(posedge clk) disable iff (rst)
    pos_win == 2'h0 |-> !late_ok)
    else $error("Closed positive window accepted a late event.");
  early_arm_a: assert property (@(posedge clk) disable iff (rst)
    start_early |=> early_pending && early_wait < 3'h3)
    else $error("Early window armed with a wrong wait.");
  early_close_a: assert property (@(posedge clk) disable iff (rst)
    (early_hit || early_miss) && !start_early |=> !early_pending)
    else $error("Early window stayed open after it was decided.");

  // Margin status counts one step per accepted early or late event and stops at fifteen.
  setup_step_a: assert property (@(posedge clk) disable iff (rst)
    (early_hit && !flag_reset && setup_status != 4'hF) |=> setup_status == $past(setup_status) + 4'h1)
    else $error("Setup status did not advance.");
  hold_step_a: assert property (@(posedge clk) disable iff (rst)
    (late_ok && !flag_reset && hold_status != 4'hF) |=> hold_status == $past(hold_status) + 4'h1)
    else $error("Hold status did not advance.");

  // Bus handshake: every access sees exactly one wait cycle.
  wait_once_a: assert property (@(posedge clk) disable iff (rst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("Access held off for more than one cycle.");
endmodule

/* src_pkg.sv */
package src_pkg;
  // Byte addresses are four times the register index.
  localparam logic [9:0] IDX_CAPTURE_CONTROL = 10'h120;
  localparam logic [9:0] IDX_SKIP_COUNT = 10'h121;
  localparam logic [9:0] IDX_SKEW_WINDOW = 10'h122;
  localparam logic [9:0] IDX_TIMESTAMP_DELAY = 10'h123;
  localparam logic [9:0] IDX_SETUP_HOLD_STATUS = 10'h128;
  localparam logic [9:0] IDX_EVENT_COUNT = 10'h12A;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h130;
  localparam logic [9:0] IDX_IRQ_ENABLE = 10'h131;
  localparam logic [9:0] IDX_IRQ_CLEAR = 10'h132;
  localparam int ADDR_W = 12;
  localparam int FLAG_RESET_BIT = 6;
  localparam int TRANS_SEL_BIT = 4;
  localparam int EDGE_SEL_BIT = 3;
  localparam int MODE_LSB = 1;
  localparam int NEG_LSB = 2;
  localparam int POS_LSB = 0;
  localparam logic [7:0] CONTROL_MASK = 8'h5E;
  localparam logic [7:0] SKIP_MASK = 8'h0F;
  localparam logic [7:0] SKEW_MASK = 8'h0F;
  localparam logic [7:0] DELAY_MASK = 8'h7F;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  localparam int DELAY_DEPTH = 128;
  localparam int PERIOD_NS = 40;
  // Irq bits: 0 event acted on, 1 event discarded by window, 2 N-shot done.
  localparam int IRQ_W = 3;
  typedef enum logic [1:0] {
    SRC_MODE_OFF = 2'h0,
    SRC_MODE_CONT = 2'h1,
    SRC_MODE_NSHOT = 2'h2
  } src_mode_t;
  typedef enum logic [1:0] {
    SRC_ST_IDLE = 2'b00,
    SRC_ST_SKIP = 2'b01,
    SRC_ST_ARMED = 2'b11,
    SRC_ST_DONE = 2'b10
  } src_state_t;
endpackage

/* src_delay_line.sv */
`timescale 1ns/1ns
// Programmable delay of a one-bit pulse, tap chosen per cycle.
module src_delay_line
  import src_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  input wire logic [6:0] tap,
  output logic dout
);
  logic [DELAY_DEPTH-1:0] shift;
  wire [DELAY_DEPTH-1:0] next_shift = {shift[DELAY_DEPTH-2:0], din};
  always_ff @(posedge clk) begin
    if (rst) begin
      shift <= '0;
      dout <= 1'b0;
    end else begin
      shift <= next_shift;
      dout <= (tap == 7'h00) ? din : shift[tap - 7'd1];
    end
  end
endmodule

/* src_sysref_source.sv */
`timescale 1ns/1ns
// Far-side clock generator: sends SYSREF pulses and marks the expected sample clock.
module src_sysref_source (
  input wire logic clk,
  output logic sysref_in,
  output logic expected_tick
);
  initial begin
    sysref_in = 1'b0;
    expected_tick = 1'b0;
  end
  // Four-cycle pulse; the tick follows the chosen transition, shifted by off cycles.
  task automatic pulse(input bit fall, input int off);
    int t;
    t = (fall ? 4 : 0) + 2 + off;
    for (int c = 0; c < 24; c++) begin
      @(posedge clk);
      sysref_in <= (c < 4);
      expected_tick <= (c == t);
    end
  endtask
endmodule

/* src_sysref_capture_tb.sv */
`timescale 1ns/1ns
module src_sysref_capture_tb;
  import src_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, sysref_in, expected_tick, sysref_event, sysref_timestamp, irq;
  logic [31:0] seed = 32'h0000_730E;
  logic [7:0] rd;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  int n_ev = 0;
  int dly, skip;
  int ev_q[$];

  always #20 clk = ~clk;

  src_sysref_capture i_src_sysref_capture (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .sysref_in, .expected_tick, .sysref_event,
    .sysref_timestamp, .irq);
  src_sysref_source i_src (.clk, .sysref_in, .expected_tick);

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // The request stands until waitrequest is seen low at a rising edge; read data is taken at that edge.
  task automatic bus(input bit wr, input logic [9:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= {idx, 2'b00};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {24'h00_0000, wd};
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 100) begin
      n++;
      @(posedge clk);
    end
    if (n >= 100) n_mismatch++;
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rchk(input logic [9:0] idx, input logic [7:0] exp);
    bus(0, idx, 8'h00);
    chk(rd, exp);
  endtask

  task automatic settle();
    repeat (140) @(posedge clk);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (sysref_event === 1'b1) begin
      n_ev++;
      ev_q.push_back(cyc);
    end
    if (sysref_timestamp === 1'b1) begin
      if (ev_q.size() == 0) chk(8'h01, 8'h00);
      else chk(8'(cyc - ev_q.pop_front()), 8'(dly));
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    dly = int'(rnd() % 128);
    skip = int'(rnd() % 16);
    rchk(IDX_CAPTURE_CONTROL, RESET_VALUE);
    rchk(IDX_SKIP_COUNT, 8'h00);
    rchk(IDX_SKEW_WINDOW, 8'h00);
    rchk(IDX_SETUP_HOLD_STATUS, 8'h00);
    rchk(IDX_EVENT_COUNT, 8'h00);
    rchk(10'h12F, 8'h00);
    bus(1, IDX_CAPTURE_CONTROL, 8'hFF);
    rchk(IDX_CAPTURE_CONTROL, 8'h5E);
    bus(1, IDX_CAPTURE_CONTROL, 8'h00);
    bus(1, IDX_SKEW_WINDOW, 8'h0F);
    bus(1, IDX_TIMESTAMP_DELAY, 8'(dly));
    bus(1, IDX_IRQ_ENABLE, 8'h07);
    bus(1, IDX_CAPTURE_CONTROL, 8'h02);
    repeat (3) i_src.pulse(0, 0);
    settle();
    chk(8'(n_ev), 8'h03);
    bus(1, IDX_CAPTURE_CONTROL, 8'h00);
    rchk(IDX_EVENT_COUNT, 8'h03);
    rchk(IDX_IRQ_STATUS, 8'h01);
    chk({7'h00, irq}, 8'h01);
    bus(1, IDX_IRQ_CLEAR, 8'h07);
    @(posedge clk);
    chk({7'h00, irq}, 8'h00);
    bus(1, IDX_CAPTURE_CONTROL, 8'h18);
    bus(1, IDX_CAPTURE_CONTROL, 8'h1A);
    repeat (2) i_src.pulse(1, 0);
    settle();
    chk(8'(n_ev), 8'h05);
    bus(1, IDX_CAPTURE_CONTROL, 8'h18);
    bus(1, IDX_CAPTURE_CONTROL, 8'h00);
    bus(1, IDX_SKIP_COUNT, 8'(skip));
    bus(1, IDX_CAPTURE_CONTROL, 8'h04);
    repeat (skip + 2) i_src.pulse(0, 0);
    settle();
    chk(8'(n_ev), 8'h06);
    rchk(IDX_IRQ_STATUS, 8'h05);
    bus(1, IDX_IRQ_CLEAR, 8'h07);
    bus(1, IDX_CAPTURE_CONTROL, 8'h00);
    bus(1, IDX_SKEW_WINDOW, 8'h00);
    bus(1, IDX_CAPTURE_CONTROL, 8'h02);
    i_src.pulse(0, 8);
    chk(8'(n_ev), 8'h06);
    rchk(IDX_IRQ_STATUS, 8'h02);
    // A tick on the very sampling edge is accepted with both windows closed.
    i_src.pulse(0, -1);
    chk(8'(n_ev), 8'h07);
    bus(1, IDX_CAPTURE_CONTROL, 8'h00);
    bus(1, IDX_SKEW_WINDOW, 8'h01);
    bus(1, IDX_CAPTURE_CONTROL, 8'h02);
    i_src.pulse(0, -2);
    chk(8'(n_ev), 8'h08);
    bus(1, IDX_CAPTURE_CONTROL, 8'h00);
    rchk(IDX_EVENT_COUNT, 8'h08);
    // Setup counts every early accept so far, saturating; hold saw the single late accept.
    rchk(IDX_SETUP_HOLD_STATUS, 8'h10 + 8'(skip > 8 ? 15 : skip + 7));
    bus(1, IDX_CAPTURE_CONTROL, 8'h40);
    rchk(IDX_SETUP_HOLD_STATUS, 8'h00);
    rchk(IDX_EVENT_COUNT, 8'h00);
    rchk(IDX_IRQ_STATUS, 8'h00);
    test_done();
  end

  // Full run needs about 1000 cycles; the limit leaves ample margin.
  initial begin
    repeat (8000) @(posedge clk);
    n_mismatch++;
    test_done();
  end
endmodule
